/* design/wdc_pkg.sv */
// Purpose: constants for the watchdog configuration block
// Assumes: apb slave, 32-bit data, one aligned word per register
// Notes: watchdog clock derived from clk_i by a divider
package wdc_pkg;
  localparam int WDC_AW = 4;
  localparam logic [WDC_AW-1:0] WDC_OFS_CFG = 4'h0;
  localparam logic [WDC_AW-1:0] WDC_OFS_CTRL = 4'h4;
  localparam logic [WDC_AW-1:0] WDC_OFS_STAT = 4'h8;
  // config word: bit 5 unimplemented, others erase to one
  localparam logic [7:0] WDC_CFG_RST = 8'hdf;
  localparam logic [7:0] WDC_CFG_MASK = 8'hdf;
  localparam int WDC_B_POWERON_EN = 7;
  localparam int WDC_B_WIN_OFF = 6;
  localparam int WDC_B_PRE_SEL = 4;
  localparam int WDC_PS_LSB = 0;
  localparam int WDC_PS_W = 4;
  // control word
  localparam int WDC_B_SW_ON = 0;
  localparam int WDC_B_CLEAR = 1;
  // status word
  localparam int WDC_B_RUNNING = 0;
  localparam int WDC_B_TIMEOUT = 1;
  localparam int WDC_B_ENABLED = 2;
  localparam int WDC_POST_LSB = 16;
  localparam int WDC_POST_W = 15;
  localparam int WDC_PRE_W = 7;
  localparam logic [WDC_PRE_W-1:0] WDC_PRE_32 = 7'h1f;
  localparam logic [WDC_PRE_W-1:0] WDC_PRE_128 = 7'h7f;
  localparam logic [WDC_POST_W-1:0] WDC_POST_ONE = 15'h0001;
  // system clock period and watchdog clock period
  localparam int WDC_CLK_NS = 40;
  localparam int WDC_TICK_NS = 32000;
  localparam int WDC_TICK_CYC = (WDC_TICK_NS + WDC_CLK_NS - 1) / WDC_CLK_NS;
  localparam int WDC_TICK_W = 10;
  localparam logic [WDC_TICK_W-1:0] WDC_TICK_LAST = WDC_TICK_W'(WDC_TICK_CYC - 1);
  typedef enum logic [2:0] {
    WDC_IDLE = 3'b001,
    WDC_RUN = 3'b010,
    WDC_BITE = 3'b100
  } wdc_state_e;
endpackage : wdc_pkg

/* design/wdc_watchdog.sv */
// Purpose: watchdog timer steered by an 8-bit configuration word over apb
// Assumes: clk_i at 25 MHz, software kicks via the control word
// Notes: window is the first half of the postscale count; a kick there bites
//
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ns
// Functional notes
// - config enable bit 7 set runs watchdog; else software enable decides
// - bit 6 set gives standard mode; cleared gives windowed mode
// - bit 4 set divides watchdog clock by 128, cleared by 32
// - four-bit postscale code n gives ratio 1:2^n, 1:1 to 1:32768
module wdc_watchdog (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [wdc_pkg::WDC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wdt_reset_o
);
  import wdc_pkg::*;

  logic [7:0] cfg, next_cfg;
  logic sw_on, next_sw_on;
  logic timeout_flag, next_timeout_flag;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  wdc_state_e state, next_state;
  logic [WDC_TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic [WDC_PRE_W-1:0] pre_cnt, next_pre_cnt;
  logic [WDC_POST_W-1:0] post_cnt, next_post_cnt;
  logic next_wdt_reset;
  logic wr_en, rd_en, kick, enabled, tick, pre_wrap, post_last, bite, early;
  logic [WDC_PRE_W-1:0] pre_last;
  logic [WDC_POST_W:0] post_ratio;
  logic [WDC_POST_W-1:0] post_end;
  logic cfg_wr;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && penable && !pready && !pwrite;
  assign kick = wr_en && (paddr == WDC_OFS_CTRL) && pwdata[WDC_B_CLEAR];
  // new ratios restart the count, so no counter is left beyond a smaller ratio
  assign cfg_wr = wr_en && (paddr == WDC_OFS_CFG);
  assign enabled = cfg[WDC_B_POWERON_EN] || sw_on;
  assign pre_last = cfg[WDC_B_PRE_SEL] ? WDC_PRE_128 : WDC_PRE_32;
  assign post_ratio = (WDC_POST_W+1)'(1) << cfg[WDC_PS_LSB +: WDC_PS_W];
  assign post_end = WDC_POST_W'(post_ratio - (WDC_POST_W+1)'(1));
  assign tick = (tick_cnt == WDC_TICK_LAST);
  assign pre_wrap = tick && (pre_cnt == pre_last);
  assign post_last = (post_cnt == post_end);
  // windowed: a kick before half the postscale count has passed is illegal
  assign early = !cfg[WDC_B_WIN_OFF] && ({1'b0, post_cnt} < (post_ratio >> 1));
  assign bite = (state == WDC_RUN) && ((pre_wrap && post_last && !kick)
                || (kick && early));

  // register file
  always_comb begin
    next_cfg = cfg;
    next_sw_on = sw_on;
    next_timeout_flag = timeout_flag;
    next_prdata = prdata;
    next_pready = psel && penable && !pready;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pslverr = !(paddr == WDC_OFS_CFG || paddr == WDC_OFS_CTRL
                       || paddr == WDC_OFS_STAT);
    end
    if (rd_en) begin
      next_prdata = '0;
      case (paddr)
        WDC_OFS_CFG: next_prdata[7:0] = cfg;
        WDC_OFS_CTRL: next_prdata[WDC_B_SW_ON] = sw_on;
        WDC_OFS_STAT: begin
          next_prdata[WDC_B_RUNNING] = (state == WDC_RUN);
          next_prdata[WDC_B_TIMEOUT] = timeout_flag;
          next_prdata[WDC_B_ENABLED] = enabled;
          next_prdata[WDC_POST_LSB +: WDC_POST_W] = post_cnt;
        end
        default: next_prdata = '0;
      endcase
    end
    if (wr_en) begin
      case (paddr)
        WDC_OFS_CFG: next_cfg = pwdata[7:0] & WDC_CFG_MASK;
        WDC_OFS_CTRL: next_sw_on = pwdata[WDC_B_SW_ON];
        WDC_OFS_STAT: begin
          if (pwdata[WDC_B_TIMEOUT]) begin
            next_timeout_flag = 1'b0;
          end
        end
        default: next_cfg = cfg;
      endcase
    end
    // a bite in the clearing cycle still sets the flag
    if (bite) begin
      next_timeout_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg <= WDC_CFG_RST;
      sw_on <= 1'b0;
      timeout_flag <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      cfg <= next_cfg;
      sw_on <= next_sw_on;
      timeout_flag <= next_timeout_flag;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // watchdog counter chain
  always_comb begin
    next_state = state;
    next_tick_cnt = tick ? '0 : tick_cnt + WDC_TICK_W'(1);
    next_pre_cnt = pre_cnt;
    next_post_cnt = post_cnt;
    next_wdt_reset = 1'b0;
    case (state)
      WDC_IDLE: begin
        next_tick_cnt = '0;
        next_pre_cnt = '0;
        next_post_cnt = '0;
        if (enabled) begin
          next_state = WDC_RUN;
        end
      end
      WDC_RUN: begin
        if (tick) begin
          next_pre_cnt = pre_wrap ? '0 : pre_cnt + WDC_PRE_W'(1);
        end
        if (pre_wrap) begin
          next_post_cnt = post_last ? '0 : post_cnt + WDC_POST_ONE;
        end
        if (kick || cfg_wr) begin
          next_tick_cnt = '0;
          next_pre_cnt = '0;
          next_post_cnt = '0;
        end
        if (bite) begin
          next_state = WDC_BITE;
          next_wdt_reset = 1'b1;
        end else if (!enabled) begin
          next_state = WDC_IDLE;
        end
      end
      WDC_BITE: begin
        // one-cycle reset pulse, then restart from zero
        next_state = WDC_IDLE;
      end
      default: next_state = WDC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= WDC_IDLE;
      tick_cnt <= '0;
      pre_cnt <= '0;
      post_cnt <= '0;
      wdt_reset_o <= 1'b0;
    end else begin
      state <= next_state;
      tick_cnt <= next_tick_cnt;
      pre_cnt <= next_pre_cnt;
      post_cnt <= next_post_cnt;
      wdt_reset_o <= next_wdt_reset;
    end
  end

  sequence s_last_step;
    state == WDC_RUN && pre_wrap && post_last && !kick;
  endsequence

  sequence s_bite_pulse;
    wdt_reset_o && state == WDC_BITE ##1 !wdt_reset_o && state == WDC_IDLE;
  endsequence

  a_off_stays_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (!cfg[WDC_B_POWERON_EN] && !sw_on && state == WDC_IDLE) |=> state == WDC_IDLE)
    else $error("watchdog left idle while disabled");

  a_window_early_kick: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == WDC_RUN && kick && !cfg[WDC_B_WIN_OFF] && post_cnt == '0
     && cfg[WDC_PS_LSB +: WDC_PS_W] != '0) |=> wdt_reset_o)
    else $error("early kick in windowed mode did not bite");

  a_std_kick_safe: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == WDC_RUN && kick && cfg[WDC_B_WIN_OFF]) |=> !wdt_reset_o)
    else $error("kick in standard mode caused a bite");

  a_prescale_bound: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    pre_cnt <= (cfg[WDC_B_PRE_SEL] ? WDC_PRE_128 : WDC_PRE_32))
    else $error("prescale count beyond selected ratio");

  a_postscale_one: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (cfg[WDC_PS_LSB +: WDC_PS_W] == 4'h0 && state == WDC_RUN) |-> post_cnt == '0)
    else $error("postscale 1:1 count moved");

  a_timeout_bite: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    s_last_step |=> s_bite_pulse)
    else $error("timeout did not give one reset pulse");

  a_flag_follows: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    bite |=> timeout_flag)
    else $error("timeout flag not set by bite");

  a_restart_zeroes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == WDC_RUN && (kick || cfg_wr) && !bite)
    |=> (tick_cnt == '0 && pre_cnt == '0 && post_cnt == '0))
    else $error("kick or config write did not restart the count");

  a_disable_idles: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == WDC_RUN && !enabled && !bite) |=> state == WDC_IDLE)
    else $error("watchdog kept running after disable");
endmodule : wdc_watchdog

/* testbench/test_watchdog_config.sv */
// Purpose: self-checking bench for the watchdog configuration block
// Assumes: apb answers with one wait state, tick of 800 clocks
// Notes: long timeouts only at 1:32 and 1:1 to keep the run short
`timescale 1ns/1ns
module test_watchdog_config;
  import wdc_pkg::*;
  logic clk_i = 0;
  logic arst_n_i = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [WDC_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic wdt_reset_o;
  logic [31:0] rd;
  logic er;
  int failures = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  wdc_watchdog dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wdt_reset_o(wdt_reset_o));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  task end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_sim
  // hang guard, tests take about 51.4k cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_sim();
    end
  end
  task chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word
  task chk_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit
  // request stands until pready is sampled high at a rising edge; hang guard ends a stall
  task apb(input logic w, input logic [WDC_AW-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wait_bite(input int lim);
    for (n = 0; n < lim; n++) begin
      @(negedge clk_i);
      if (wdt_reset_o === 1'b1) break;
    end
  endtask : wait_bite
  task t_regs;
    apb(0, WDC_OFS_STAT, 0);
    chk_bit("poweron running", 1'b1, rd[WDC_B_RUNNING]);
    apb(0, WDC_OFS_CFG, 0);
    chk_word("cfg reset", 32'h000000df, rd);
    chk_bit("cfg err", 1'b0, er);
    apb(1, WDC_OFS_CFG, 32'h000000ff);
    apb(0, WDC_OFS_CFG, 0);
    chk_word("cfg masked", 32'h000000df, rd);
    apb(0, 4'hc, 0);
    chk_bit("unmapped err", 1'b1, er);
    chk_word("unmapped data", 32'h00000000, rd);
  endtask : t_regs
  task t_enable;
    apb(1, WDC_OFS_CFG, 32'h00000040);
    apb(1, WDC_OFS_CTRL, 32'h00000000);
    apb(0, WDC_OFS_STAT, 0);
    chk_bit("off enabled", 1'b0, rd[WDC_B_ENABLED]);
    apb(1, WDC_OFS_CTRL, 32'h00000003);
    wait_bite(27000);
    // 800 clocks a tick, 1:32, 1:1
    chk_bit("bite time", 1'b1, n >= 25590 && n <= 25610);
    apb(0, WDC_OFS_STAT, 0);
    chk_bit("timeout flag", 1'b1, rd[WDC_B_TIMEOUT]);
  endtask : t_enable
  task t_window;
    apb(1, WDC_OFS_CFG, 32'h00000001);
    apb(1, WDC_OFS_CTRL, 32'h00000003);
    wait_bite(6);
    chk_bit("early kick bite", 1'b1, n < 6);
    apb(1, WDC_OFS_CFG, 32'h00000041);
    apb(1, WDC_OFS_CTRL, 32'h00000003);
    wait_bite(10);
    chk_bit("standard kick", 1'b1, n == 10);
  endtask : t_window
  task t_pre128;
    apb(1, WDC_OFS_CFG, 32'h00000050);
    apb(1, WDC_OFS_CTRL, 32'h00000003);
    // a 1:32 divide would bite near 25600
    wait_bite(25700);
    chk_bit("no bite at 1:128", 1'b1, n == 25700);
  endtask : t_pre128
  initial begin
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1;
    t_regs();
    t_enable();
    t_window();
    t_pre128();
    end_sim();
  end
endmodule : test_watchdog_config
